// ===== rtl/bidir_fifo_cmd_pkg.sv
// bidir_fifo_cmd_pkg: constants and types of the command and configuration unit
// assumes one 10 MHz clock; host port pins arrive asynchronous to it
package bidir_fifo_cmd_pkg;
	// command opcodes
	localparam logic [3:0] OP_RESET     = 4'h0;
	localparam logic [3:0] OP_SELECT    = 4'h1;
	localparam logic [3:0] OP_SAVE_RD   = 4'h2;
	localparam logic [3:0] OP_SAVE_WR   = 4'h3;
	localparam logic [3:0] OP_LOAD_RD   = 4'h4;
	localparam logic [3:0] OP_LOAD_WR   = 4'h5;
	localparam logic [3:0] OP_DIRECTION = 4'h6;
	localparam logic [3:0] OP_INC_RD    = 4'h8;
	localparam logic [3:0] OP_INC_WR    = 4'h9;
	// reset operands
	localparam logic [2:0] RST_BA   = 3'h1;
	localparam logic [2:0] RST_AB   = 3'h2;
	localparam logic [2:0] RST_BOTH = 3'h3;
	localparam logic [2:0] RST_DMA  = 3'h4;
	localparam logic [2:0] RST_ALL  = 3'h7;
	// host address decode {hi, lo}
	localparam logic [1:0] ADDR_CONFIG = 2'h2;
	localparam logic [1:0] ADDR_CMD    = 2'h3;
	// configuration register indices
	localparam logic [2:0] CFG_ROUTE = 3'h4;
	localparam logic [2:0] CFG_CTRL  = 3'h5;
	localparam logic [2:0] CFG_PIO   = 3'h6;
	localparam logic [2:0] CFG_DIR   = 3'h7;
	// reset values
	localparam logic [15:0] CFG_ZERO    = 16'h0000;
	localparam logic [15:0] ROUTE_RESET = 16'h6420;
	localparam logic        DIR_RESET   = 1'b0;
	// command field positions
	localparam int OPC_LSB = 8;
	localparam int OPR_LSB = 0;
	// control register bit positions
	localparam int CB_STYLE  = 0;
	localparam int CB_FULLD  = 2;
	localparam int CB_EMPTYD = 3;
	localparam int CB_REQPOL = 4;
	localparam int CB_ACKPOL = 5;
	localparam int CB_DELAY  = 6;
	localparam int CB_WIDTH  = 8;
	localparam int CB_HALF   = 9;
	localparam int CB_PERIPH = 10;
	// status bit positions
	localparam int ST_DIR = 3;
	localparam int ST_LO  = 4;
	localparam int ST_HI  = 12;
	// request-to-acknowledge base delay in peripheral clock ticks
	localparam logic [2:0] ACK_BASE = 3'h2;
	// offset width and pin counts
	localparam int OFS_W = 10;
	localparam int PIO_N = 6;

	// peripheral-side DMA pins, all registered
	typedef struct packed {
		logic req;
		logic ack;
		logic readStrobe_n;
		logic writeStrobe_n;
		logic dataStrobe_n;
		logic rwLine;
	} dma_pins_t;

	// pointer set of one direction
	typedef struct packed {
		logic [OFS_W-1:0] rd;
		logic [OFS_W-1:0] wr;
		logic [OFS_W-1:0] save;
	} ptr_set_t;
endpackage : bidir_fifo_cmd_pkg

// ===== rtl/bidir_fifo_command_config_unit.sv
// bidir_fifo_command_config_unit: command decoder, config registers, status and DMA pacing
// assumes host pins and peripheral clock pin are asynchronous; flags come from same clock
`timescale 1ns/100ps
module bidir_fifo_command_config_unit (
	// clock and reset
	input  wire logic                                clk,
	input  wire logic                                reset,
	// host port pins
	input  wire logic                                host_chip_select_n,
	input  wire logic                                host_addr_hi,
	input  wire logic                                host_addr_lo,
	input  wire logic                                hostRead,
	input  wire logic                                hostDataStrobe_n,
	input  wire logic [15:0]                         hostDataIn,
	output logic      [15:0]                         hostDataOut,
	output logic                                     hostDataOe_n,
	// internal flags: ab empty, ae, full, af, ba empty, ae, full, af
	input  wire logic [7:0]                          fifoFlags,
	output logic                                     ext_flag_pin_a,
	output logic                                     ext_flag_pin_b,
	output logic                                     ext_flag_pin_c,
	output logic                                     ext_flag_pin_d,
	// pointers and configuration to the storage side
	output bidir_fifo_cmd_pkg::ptr_set_t             abPtr,
	output bidir_fifo_cmd_pkg::ptr_set_t             baPtr,
	output logic [15:0]                              offsetOut [4],
	output logic [15:0]                              controlOut,
	output logic                                     dmaDirection,
	// peripheral DMA side
	input  wire logic                                periphClkPin,
	input  wire logic                                dmaDataReady,
	output bidir_fifo_cmd_pkg::dma_pins_t            dmaPins,
	output logic                                     periphCtrlOe_n,
	// programmable I/O pins
	input  wire logic [5:0]                          programmable_io_pin_in,
	output logic      [5:0]                          programmable_io_pin_out,
	output logic      [5:0]                          programmable_io_pin_oe_n
);
	localparam int SW = 28;

	////////////////////////////////////////////////////////////////////////////////
	// input synchronisers
	logic [SW-1:0] meta;
	logic [SW-1:0] sync;
	logic          strobePrev;
	logic          clkPinPrev;

	// two flops per asynchronous input
	always_ff @(posedge clk) begin
		meta       <= {host_chip_select_n, host_addr_hi, host_addr_lo, hostRead,
			hostDataStrobe_n, programmable_io_pin_in, periphClkPin, hostDataIn};
		sync       <= meta;
		strobePrev <= sync[23];
		clkPinPrev <= sync[16];
	end

	wire        sCs_n    = sync[27];
	wire [1:0]  sAddr    = sync[26:25];
	wire        sRead    = sync[24];
	wire        sStrobe  = ~sync[23];
	wire [5:0]  sPio     = sync[22:17];
	wire        sClkPin  = sync[16];
	wire [15:0] sData    = sync[15:0];
	wire        startAcc = sStrobe & strobePrev & ~sCs_n;
	wire        cfgWrite = startAcc & ~sRead & (sAddr == bidir_fifo_cmd_pkg::ADDR_CONFIG);
	wire        cmdWrite = startAcc & ~sRead & (sAddr == bidir_fifo_cmd_pkg::ADDR_CMD);
	wire [3:0]  opcode   = sData[bidir_fifo_cmd_pkg::OPC_LSB +: 4];
	wire [2:0]  operand  = sData[bidir_fifo_cmd_pkg::OPR_LSB +: 3];

	////////////////////////////////////////////////////////////////////////////////
	// command decode
	wire isReset   = cmdWrite & (opcode == bidir_fifo_cmd_pkg::OP_RESET);
	wire resetAll  = isReset & (operand == bidir_fifo_cmd_pkg::RST_ALL);
	wire clearBa   = reset | resetAll | isReset & (operand == bidir_fifo_cmd_pkg::RST_BA |
		operand == bidir_fifo_cmd_pkg::RST_BOTH);
	wire clearAb   = reset | resetAll | isReset & (operand == bidir_fifo_cmd_pkg::RST_AB |
		operand == bidir_fifo_cmd_pkg::RST_BOTH);
	wire clearDma  = resetAll | isReset & (operand == bidir_fifo_cmd_pkg::RST_DMA);
	wire doSelect  = cmdWrite & (opcode == bidir_fifo_cmd_pkg::OP_SELECT);
	wire doSaveRd  = cmdWrite & (opcode == bidir_fifo_cmd_pkg::OP_SAVE_RD);
	wire doSaveWr  = cmdWrite & (opcode == bidir_fifo_cmd_pkg::OP_SAVE_WR);
	wire doLoadRd  = cmdWrite & (opcode == bidir_fifo_cmd_pkg::OP_LOAD_RD);
	wire doLoadWr  = cmdWrite & (opcode == bidir_fifo_cmd_pkg::OP_LOAD_WR);
	wire doIncRd   = cmdWrite & (opcode == bidir_fifo_cmd_pkg::OP_INC_RD);
	wire doIncWr   = cmdWrite & (opcode == bidir_fifo_cmd_pkg::OP_INC_WR);
	wire periph    = controlOut[bidir_fifo_cmd_pkg::CB_PERIPH];
	wire doDir     = cmdWrite & (opcode == bidir_fifo_cmd_pkg::OP_DIRECTION) & periph;

	////////////////////////////////////////////////////////////////////////////////
	// pointers
	logic [2:0] cfgSelect;

	// host-to-peripheral pointers: read side is the peripheral port
	always_ff @(posedge clk) begin
		if (clearAb) begin
			abPtr <= '0;
		end else if (doSaveRd) begin
			abPtr.save <= abPtr.rd;
		end else if (doLoadRd) begin
			abPtr.rd <= abPtr.save;
		end else if (doIncRd) begin
			abPtr.rd <= abPtr.rd + 10'h001;
		end
	end

	// peripheral-to-host pointers: write side is the peripheral port
	always_ff @(posedge clk) begin
		if (clearBa) begin
			baPtr <= '0;
		end else if (doSaveWr) begin
			baPtr.save <= baPtr.wr;
		end else if (doLoadWr) begin
			baPtr.wr <= baPtr.save;
		end else if (doIncWr) begin
			baPtr.wr <= baPtr.wr + 10'h001;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// configuration registers, selection and direction
	logic [15:0] routeReg;
	logic [15:0] pioData;
	logic [15:0] pioDirMask;
	wire         cfgClear = reset | resetAll;

	// selected register follows the last select command
	always_ff @(posedge clk) begin
		if (reset) begin
			cfgSelect <= 3'h0;
		end else if (doSelect) begin
			cfgSelect <= operand;
		end
	end

	// offsets: full 16 bits stored, only low 10 meaningful
	for (genvar i = 0; i < 4; i++) begin : g_ofs
		always_ff @(posedge clk) begin
			if (cfgClear) begin
				offsetOut[i] <= bidir_fifo_cmd_pkg::CFG_ZERO;
			end else if (cfgWrite && cfgSelect == 3'(i)) begin
				offsetOut[i] <= sData;
			end
		end
	end

	// flag routing, control, I/O data and direction
	always_ff @(posedge clk) begin
		if (cfgClear) begin
			routeReg   <= bidir_fifo_cmd_pkg::ROUTE_RESET;
			controlOut <= bidir_fifo_cmd_pkg::CFG_ZERO;
			pioData    <= bidir_fifo_cmd_pkg::CFG_ZERO;
			pioDirMask <= bidir_fifo_cmd_pkg::CFG_ZERO;
		end else if (cfgWrite) begin
			if (cfgSelect == bidir_fifo_cmd_pkg::CFG_ROUTE) routeReg <= sData;
			if (cfgSelect == bidir_fifo_cmd_pkg::CFG_CTRL) controlOut <= sData;
			if (cfgSelect == bidir_fifo_cmd_pkg::CFG_PIO) pioData <= sData;
			if (cfgSelect == bidir_fifo_cmd_pkg::CFG_DIR) pioDirMask <= sData;
		end
	end

	// direction survives reset-all; only hardware reset clears it
	always_ff @(posedge clk) begin
		if (reset) begin
			dmaDirection <= bidir_fifo_cmd_pkg::DIR_RESET;
		end else if (doDir) begin
			dmaDirection <= operand[0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// host read data, flag pins and I/O pins
	wire [15:0] pioRead   = {10'h000, (pioDirMask[5:0] & pioData[5:0]) | (~pioDirMask[5:0] & sPio)};
	wire [15:0] status    = {fifoFlags[5], fifoFlags[4], fifoFlags[3], fifoFlags[2], 4'h0,
		fifoFlags[7], fifoFlags[6], fifoFlags[1], fifoFlags[0], dmaDirection, 3'h0};
	wire [15:0] cfgRead   = (cfgSelect < 3'h4) ? offsetOut[cfgSelect[1:0]] :
		(cfgSelect == bidir_fifo_cmd_pkg::CFG_ROUTE) ? routeReg :
		(cfgSelect == bidir_fifo_cmd_pkg::CFG_CTRL) ? controlOut :
		(cfgSelect == bidir_fifo_cmd_pkg::CFG_PIO) ? pioRead : pioDirMask;
	wire        readNow   = sStrobe & ~sCs_n & sRead & sAddr[1];
	wire [15:0] next_data = (sAddr == bidir_fifo_cmd_pkg::ADDR_CMD) ? status : cfgRead;

	// selects one internal flag by its routing code; codes 8-15 repeat 0-7
	function automatic logic pickFlag(input logic [3:0] code, input logic [7:0] flags);
		return flags[code[2:0]];
	endfunction : pickFlag

	// registered host bus, flag pins and I/O drive
	always_ff @(posedge clk) begin
		hostDataOut              <= readNow ? next_data : 16'h0000;
		hostDataOe_n             <= ~readNow;
		ext_flag_pin_a           <= pickFlag(routeReg[3:0], fifoFlags);
		ext_flag_pin_b           <= pickFlag(routeReg[7:4], fifoFlags);
		ext_flag_pin_c           <= pickFlag(routeReg[11:8], fifoFlags);
		ext_flag_pin_d           <= pickFlag(routeReg[15:12], fifoFlags);
		programmable_io_pin_out  <= pioData[5:0];
		programmable_io_pin_oe_n <= ~pioDirMask[5:0];
		periphCtrlOe_n           <= ~periph;
	end

	////////////////////////////////////////////////////////////////////////////////
	// DMA pacing on the internal clock
	typedef enum logic [1:0] {DMA_IDLE, DMA_REQ, DMA_STROBE} dma_state_t;
	dma_state_t dmaState;
	logic [2:0] dmaCount;
	logic       halfPhase;
	wire        pinRise  = sClkPin & ~clkPinPrev;
	wire        tick     = pinRise & (~controlOut[bidir_fifo_cmd_pkg::CB_HALF] | halfPhase);
	wire [2:0]  ackDelay = bidir_fifo_cmd_pkg::ACK_BASE +
		{1'b0, controlOut[bidir_fifo_cmd_pkg::CB_DELAY +: 2]};
	wire [2:0]  strobeW  = controlOut[bidir_fifo_cmd_pkg::CB_WIDTH] ? 3'h2 : 3'h1;
	wire        cntDone  = (dmaCount == 3'h1);

	// halving toggle and request/acknowledge/strobe sequence
	always_ff @(posedge clk) begin
		if (reset) begin
			halfPhase <= 1'b0;
		end else if (pinRise) begin
			halfPhase <= ~halfPhase;
		end
		if (reset || clearDma || !periph) begin
			dmaState <= DMA_IDLE;
			dmaCount <= 3'h0;
		end else if (tick) begin
			case (dmaState)
				DMA_IDLE: if (dmaDataReady) begin
					dmaState <= DMA_REQ;
					dmaCount <= ackDelay;
				end
				DMA_REQ: if (cntDone) begin
					dmaState <= DMA_STROBE;
					dmaCount <= strobeW;
				end else begin
					dmaCount <= dmaCount - 3'h1;
				end
				DMA_STROBE: if (cntDone) begin
					dmaState <= DMA_IDLE;
				end else begin
					dmaCount <= dmaCount - 3'h1;
				end
				default: dmaState <= DMA_IDLE;
			endcase
		end
	end

	wire reqOn  = (dmaState != DMA_IDLE);
	wire ackOn  = (dmaState == DMA_STROBE);
	wire style  = controlOut[bidir_fifo_cmd_pkg::CB_STYLE];
	wire reqPol = controlOut[bidir_fifo_cmd_pkg::CB_REQPOL];
	wire ackPol = controlOut[bidir_fifo_cmd_pkg::CB_ACKPOL];
	bidir_fifo_cmd_pkg::dma_pins_t next_pins;
	assign next_pins.req           = reqOn ^ reqPol;
	assign next_pins.ack           = ackOn ~^ ackPol;
	assign next_pins.readStrobe_n  = ~(ackOn & ~style & dmaDirection);
	assign next_pins.writeStrobe_n = ~(ackOn & ~style & ~dmaDirection);
	assign next_pins.dataStrobe_n  = ~(ackOn & style);
	assign next_pins.rwLine        = dmaDirection;

	// registered DMA pins
	always_ff @(posedge clk) begin
		dmaPins <= next_pins;
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	sequence cmdSeen(logic [3:0] op);
		cmdWrite && opcode == op;
	endsequence

	save_read_ptr_a: assert property (@(posedge clk) disable iff (reset)
		cmdSeen(bidir_fifo_cmd_pkg::OP_SAVE_RD) |=> abPtr.save == $past(abPtr.rd))
		else $error("reread pointer not saved");
	restore_write_ptr_a: assert property (@(posedge clk) disable iff (reset)
		cmdSeen(bidir_fifo_cmd_pkg::OP_LOAD_WR) |=> baPtr.wr == $past(baPtr.save))
		else $error("write pointer not restored");
	inc_read_ptr_a: assert property (@(posedge clk) disable iff (reset)
		cmdSeen(bidir_fifo_cmd_pkg::OP_INC_RD) |=> abPtr.rd == $past(abPtr.rd) + 10'h001)
		else $error("read pointer not advanced");
	reset_ba_ptr_a: assert property (@(posedge clk) disable iff (reset)
		isReset && operand == bidir_fifo_cmd_pkg::RST_BA |=> baPtr == '0 && $stable(abPtr))
		else $error("operand 001 reset wrong set");
	reset_all_cfg_a: assert property (@(posedge clk) disable iff (reset)
		resetAll |=> routeReg == bidir_fifo_cmd_pkg::ROUTE_RESET && $stable(dmaDirection)
		##1 dmaState == DMA_IDLE)
		else $error("reset all wrong");
	hw_reset_state_a: assert property (@(posedge clk)
		reset |=> routeReg == bidir_fifo_cmd_pkg::ROUTE_RESET && controlOut == 16'h0000
		&& abPtr == '0 && baPtr == '0 && !dmaDirection && cfgSelect == 3'h0)
		else $error("hardware reset state wrong");
	select_cfg_a: assert property (@(posedge clk) disable iff (reset)
		cmdSeen(bidir_fifo_cmd_pkg::OP_SELECT) |=> cfgSelect == $past(operand))
		else $error("config select not taken");
	dir_periph_only_a: assert property (@(posedge clk) disable iff (reset)
		cmdWrite && opcode == bidir_fifo_cmd_pkg::OP_DIRECTION && !periph |=> $stable(dmaDirection))
		else $error("direction changed in processor mode");
	// further pointer, reset, pin and status checks
	reset_ab_ptr_a: assert property (@(posedge clk) disable iff (reset)
		isReset && operand == bidir_fifo_cmd_pkg::RST_AB |=> abPtr == '0 && $stable(baPtr))
		else $error("operand 010 reset wrong set");
	reset_both_ptr_a: assert property (@(posedge clk) disable iff (reset)
		isReset && operand == bidir_fifo_cmd_pkg::RST_BOTH |=> abPtr == '0 && baPtr == '0)
		else $error("operand 011 reset incomplete");
	reset_dma_idle_a: assert property (@(posedge clk) disable iff (reset)
		clearDma |=> dmaState == DMA_IDLE)
		else $error("dma request not cleared");
	save_write_ptr_a: assert property (@(posedge clk) disable iff (reset)
		cmdSeen(bidir_fifo_cmd_pkg::OP_SAVE_WR) |=> baPtr.save == $past(baPtr.wr))
		else $error("rewrite pointer not saved");
	restore_read_ptr_a: assert property (@(posedge clk) disable iff (reset)
		cmdSeen(bidir_fifo_cmd_pkg::OP_LOAD_RD) |=> abPtr.rd == $past(abPtr.save))
		else $error("read pointer not restored");
	inc_write_ptr_a: assert property (@(posedge clk) disable iff (reset)
		cmdSeen(bidir_fifo_cmd_pkg::OP_INC_WR) |=> baPtr.wr == $past(baPtr.wr) + 10'h001)
		else $error("write pointer not advanced");
	set_direction_a: assert property (@(posedge clk) disable iff (reset)
		cmdWrite && opcode == bidir_fifo_cmd_pkg::OP_DIRECTION && periph
		|=> dmaDirection == $past(operand[0]))
		else $error("direction not taken");
	offset_clear_a: assert property (@(posedge clk) disable iff (reset)
		resetAll |=> offsetOut[0] == 16'h0000 && offsetOut[3] == 16'h0000)
		else $error("offsets not cleared");
	periph_oe_a: assert property (@(posedge clk) disable iff (reset)
		1'b1 |=> periphCtrlOe_n == !$past(periph))
		else $error("peripheral pin enable wrong");
	pio_drive_a: assert property (@(posedge clk) disable iff (reset)
		1'b1 |=> programmable_io_pin_out == $past(pioData[5:0]))
		else $error("io pin drive wrong");
	pio_enable_a: assert property (@(posedge clk) disable iff (reset)
		1'b1 |=> programmable_io_pin_oe_n == ~$past(pioDirMask[5:0]))
		else $error("io pin direction wrong");
	status_read_a: assert property (@(posedge clk) disable iff (reset)
		readNow && sAddr == bidir_fifo_cmd_pkg::ADDR_CMD
		|=> hostDataOut == $past(status) && !hostDataOe_n)
		else $error("status read wrong");
	flag_route_a: assert property (@(posedge clk) disable iff (reset)
		##1 ext_flag_pin_c == $past(fifoFlags[routeReg[10:8]]))
		else $error("flag pin c misrouted");
	ack_delay_a: assert property (@(posedge clk) disable iff (reset || clearDma || !periph)
		dmaState == DMA_IDLE && tick && dmaDataReady |=> dmaState == DMA_REQ [*1] ##1
		dmaCount == $past(ackDelay, 2))
		else $error("ack delay count wrong");
endmodule : bidir_fifo_command_config_unit

// ===== dv/host_cpu_model.sv
// host_cpu_model: host processor on the controlling port, one pin-level access per call
// assumes the device samples pins through two flops and answers within five cycles
`timescale 1ns/100ps
module host_cpu_model (
	// clock
	input  wire logic        clk,
	// read data from the device
	input  wire logic [15:0] dataIn,
	// host pins
	output logic             cs_n,
	output logic             addrHi,
	output logic             addrLo,
	output logic             rdSel,
	output logic             strobe_n,
	output logic [15:0]      dataOut
);
	// idle bus at time zero
	initial begin
		cs_n     = 1'b1;
		addrHi   = 1'b0;
		addrLo   = 1'b0;
		rdSel    = 1'b0;
		strobe_n = 1'b1;
		dataOut  = 16'h0000;
	end
	////////////////////////////////////////////////////////////////////////////////
	// strobe low five cycles, high at least five, pins held while low
	task automatic access(input logic [1:0] a, input logic r, input logic [15:0] w,
		output logic [15:0] q);
		@(negedge clk);
		cs_n            = 1'b0; // command words carry opcode 11:8, operand 2:0
		{addrHi, addrLo} = a;
		rdSel           = r;
		dataOut         = w;
		strobe_n        = 1'b0;
		repeat (5) @(negedge clk);
		q        = dataIn;
		strobe_n = 1'b1;
		repeat (4) @(negedge clk);
		cs_n    = 1'b1;
		dataOut = ~dataOut; // released bus shows no stale value
	endtask : access
endmodule : host_cpu_model

// ===== dv/tb_bidir_fifo_command_config_unit.sv
// tb_bidir_fifo_command_config_unit: register table, pointer commands, flags, DMA, resets
// assumes host_cpu_model drives the host pins; inputs change at falling edges
`timescale 1ns/100ps
module tb_bidir_fifo_command_config_unit;
	typedef struct packed {logic [2:0] idx; logic [15:0] rst; logic [15:0] wr;} cfg_row_t;
	typedef struct packed {logic [15:0] cmd; logic [29:0] ab; logic [29:0] ba;} ptr_row_t;
	logic clk = 0, reset = 1, cs_n, hi, lo, rdSel, strobe_n, pClk = 0, pRun = 0;
	logic dmaReady = 0, pinA, pinB, pinC, pinD, dmaDir, pCtrlOe_n;
	logic [15:0] hostIn, hostOut, q, offs [4], ctrl;
	logic [7:0]  flags = 8'h00;
	logic        hostOe_n;
	logic [5:0]  pioIn = 6'h0F, pioOut, pioOe_n;
	bidir_fifo_cmd_pkg::ptr_set_t  abPtr, baPtr;
	bidir_fifo_cmd_pkg::dma_pins_t dmaPins;
	int bad_count = 0, checked = 0, cycles = 0, n;
	// register cases: bit 9 of offsets written zero
	cfg_row_t cfgRows [7] = '{'{3'h0, 16'h0000, 16'h01FF}, '{3'h1, 16'h0000, 16'h0155},
		'{3'h2, 16'h0000, 16'h00AA}, '{3'h3, 16'h0000, 16'h0100},
		'{3'h4, 16'h6420, 16'h7531}, '{3'h5, 16'h0000, 16'h0001},
		'{3'h7, 16'h0000, 16'h0015}};
	// pointer cases, each set packed {rd, wr, save} at 10 bits
	ptr_row_t ptrRows [18] = '{'{16'h0003, 30'h0, 30'h0}, '{16'h0800, 30'h100000, 30'h0},
		'{16'h0200, 30'h100001, 30'h0}, '{16'h0800, 30'h200001, 30'h0},
		'{16'h0400, 30'h100001, 30'h0}, '{16'h0900, 30'h100001, 30'h400},
		'{16'h0300, 30'h100001, 30'h401}, '{16'h0900, 30'h100001, 30'h801},
		'{16'h0500, 30'h100001, 30'h401}, '{16'h0700, 30'h100001, 30'h401},
		'{16'h0A00, 30'h100001, 30'h401}, '{16'h0005, 30'h100001, 30'h401},
		'{16'h0006, 30'h100001, 30'h401}, '{16'h0000, 30'h100001, 30'h401},
		'{16'h0001, 30'h100001, 30'h0}, '{16'h0900, 30'h100001, 30'h400},
		'{16'h0002, 30'h0, 30'h400}, '{16'h0007, 30'h0, 30'h0}};
	// clocks and hang guard
	always #50 clk = ~clk;
	always #300 if (pRun) pClk = ~pClk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			bad_count++;
			end_of_test();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	host_cpu_model u_host (.clk(clk), .dataIn(hostOut), .cs_n(cs_n), .addrHi(hi),
		.addrLo(lo), .rdSel(rdSel), .strobe_n(strobe_n), .dataOut(hostIn));
	bidir_fifo_command_config_unit u_dut (.clk(clk), .reset(reset),
		.host_chip_select_n(cs_n), .host_addr_hi(hi), .host_addr_lo(lo), .hostRead(rdSel),
		.hostDataStrobe_n(strobe_n), .hostDataIn(hostIn), .hostDataOut(hostOut),
		.hostDataOe_n(hostOe_n), .fifoFlags(flags), .ext_flag_pin_a(pinA),
		.ext_flag_pin_b(pinB), .ext_flag_pin_c(pinC), .ext_flag_pin_d(pinD),
		.abPtr(abPtr), .baPtr(baPtr), .offsetOut(offs), .controlOut(ctrl),
		.dmaDirection(dmaDir), .periphClkPin(pClk), .dmaDataReady(dmaReady),
		.dmaPins(dmaPins), .periphCtrlOe_n(pCtrlOe_n), .programmable_io_pin_in(pioIn),
		.programmable_io_pin_out(pioOut), .programmable_io_pin_oe_n(pioOe_n));
	////////////////////////////////////////////////////////////////////////////////
	// comparison, bus helpers and closing report
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [1:0] a, input logic [15:0] d);
		logic [15:0] x;
		u_host.access(a, 1'b0, d, x);
	endtask : wr
	task automatic rd(input logic [1:0] a, output logic [15:0] d);
		u_host.access(a, 1'b1, 16'h0000, d);
	endtask : rd
	task automatic end_of_test();
		$display("checked=%0d bad_count=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test
	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (16) @(negedge clk);
		reset = 0;
		for (int i = 0; i < 7; i++) begin
			wr(2'h3, {13'h0020, cfgRows[i].idx});
			rd(2'h2, q);
			chk(64'(q), 64'(cfgRows[i].rst));
			wr(2'h2, cfgRows[i].wr);
			rd(2'h2, q);
			chk(64'(q), 64'(cfgRows[i].wr));
		end
		chk({offs[0], offs[1], offs[2], offs[3]}, 64'h01FF015500AA0100);
		chk(64'(ctrl), 64'h1);
		$display("test registers done");
		flags = 8'h96;
		repeat (3) @(negedge clk);
		chk(64'({pinD, pinC, pinB, pinA}), 64'({flags[7], flags[5], flags[3], flags[1]}));
		rd(2'h3, q);
		chk(64'({q[15:12], q[7:3]}), 64'({flags[5:2], flags[7:6], flags[1:0], 1'b0}));
		chk(64'(hostOe_n), 64'h1);
		$display("test flags done");
		wr(2'h3, 16'h0601);
		chk(64'(dmaDir), 64'h0);
		wr(2'h3, 16'h0105);
		wr(2'h2, 16'h0400);
		chk(64'(pCtrlOe_n), 64'h0);
		wr(2'h3, 16'h0601);
		chk(64'(dmaDir), 64'h1);
		rd(2'h3, q);
		chk(64'(q[3]), 64'h1);
		dmaReady = 1;
		pRun = 1;
		for (n = 0; n < 300 && dmaPins.req !== 1'b1; n++) @(negedge clk);
		chk(64'(dmaPins.req), 64'h1);
		for (n = 0; n < 300 && dmaPins.ack !== 1'b0; n++) @(negedge clk);
		chk(64'({dmaPins.ack, dmaPins.readStrobe_n, dmaPins.writeStrobe_n, dmaPins.dataStrobe_n,
			dmaPins.rwLine}), 64'h07);
		dmaReady = 0;
		pRun = 0;
		wr(2'h3, 16'h0004);
		chk(64'(dmaPins.req), 64'h0);
		$display("test direction and dma done");
		for (int i = 0; i < 18; i++) begin
			wr(2'h3, ptrRows[i].cmd);
			chk(64'({abPtr, baPtr}), 64'({ptrRows[i].ab, ptrRows[i].ba}));
		end
		chk(64'({dmaDir, ctrl}), 64'h10000);
		wr(2'h3, 16'h0104);
		rd(2'h2, q);
		chk(64'(q), 64'h6420);
		$display("test pointers done");
		wr(2'h3, 16'h0107);
		wr(2'h2, 16'h0015);
		chk(64'(pioOe_n), 64'h2A);
		wr(2'h3, 16'h0106);
		wr(2'h2, 16'h002A);
		chk(64'(pioOut), 64'h2A);
		rd(2'h2, q);
		chk(64'(q[5:0]), 64'h0A);
		$display("test pio done");
		wr(2'h3, 16'h0800);
		@(negedge clk);
		reset = 1;
		repeat (16) @(negedge clk);
		reset = 0;
		repeat (2) @(negedge clk);
		chk(64'({dmaDir, abPtr, baPtr}), 64'h0);
		wr(2'h2, 16'h0123);
		chk(64'(offs[0]), 64'h0123);
		$display("test hardware reset done");
		end_of_test();
	end
endmodule : tb_bidir_fifo_command_config_unit
